// ===== ascc_pkg.sv
/*
 * Shared constants and types for the externally clocked conversion sequencer:
 * command byte layouts, mode codes, DAC word layout, byte counts and timing.
 * Assumes a 25 MHz core clock; the cycle counts are derived from that period.
 */
package ascc_pkg;

   // Clock mode field codes
   localparam logic [1:0] MODE_EXT_SCLK   = 2'h3;
   localparam logic [1:0] MODE_INT_CMD    = 2'h2;
   localparam logic [1:0] MODE_RESET      = MODE_INT_CMD;
   localparam logic [1:0] SCAN_REPEAT     = 2'h2;

   // Command byte decoding
   localparam logic [7:0] NOP_BYTE        = 8'h00;
   localparam logic [1:0] SETUP_TAG       = 2'h1;
   localparam int         SETUP_MODE_LSB  = 4;
   localparam logic [3:0] RESET_TAG       = 4'h1;
   localparam int         RESET_BIAS_BIT  = 3;
   localparam logic [3:0] DAC_TAG         = 4'h3;
   localparam logic [1:0] DAC_DATA_BYTES  = 2'h2;

   // Byte and bit counts
   localparam logic [1:0] NOP_POWER_DOWN  = 2'h2;
   localparam logic [4:0] TEMP_NOP_BYTES  = 5'h18;
   localparam logic [4:0] TEMP_OUT_BYTES  = 5'h02;
   localparam logic [4:0] RESULT_BITS     = 5'h10;
   localparam logic [3:0] LEAD_ZEROS      = 4'h0;
   localparam logic [11:0] DAC_RESET_CODE = 12'h000;

   // Timing
   localparam int          CORE_PERIOD_NS = 40;
   localparam int          TEMP_TIME_NS   = 53100;
   localparam int          CONV_TIME_NS   = 4000;
   localparam logic [15:0] TEMP_CYCLES    = 16'((TEMP_TIME_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS);
   localparam logic [15:0] CONV_CYCLES    = 16'((CONV_TIME_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS);

   typedef struct packed {
      logic       is_conv;
      logic [3:0] chan;
      logic [1:0] scan;
      logic       temp;
   } ascc_conv_cmd_type;

   typedef struct packed {
      logic        sw_load;
      logic [2:0]  chan;
      logic [11:0] code;
   } ascc_dac_word_type;

   typedef enum logic [1:0] {CV_IDLE, CV_RUN, CV_TEMP} ascc_conv_state_type;
   typedef enum logic [1:0] {DW_IDLE, DW_HI, DW_LO, DW_FULL} ascc_dac_state_type;

endpackage

// ===== ascc_sync.sv
/*
 * Three-flop input synchroniser with agreement filter.
 * Assumes d comes from another clock domain or a pin; q changes only when
 * the second and third stages agree.
 */
`timescale 1ns/1ps
module ascc_sync #(
   parameter int           W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s1_r <= INIT;
         s2_r <= INIT;
         s3_r <= INIT;
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // Each bit follows only once two stages agree
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q <= INIT;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (s2_r[i] == s3_r[i]) begin
               q[i] <= s3_r[i];
            end
         end
      end
   end
endmodule

// ===== ascc_top.sv
/*
 * Externally clocked conversion sequencer with DAC load control.
 * Link side runs on SCLK and is framed by CS_N; the core side runs on CORE_CLK.
 * Assumes SCLK idles while CS_N is high and ADC_RESULT/TEMP_RESULT are core-domain.
 */
// What this block does
// - Mode 11 disables scanning and averaging; result shifts out during conversion.
// - Mode 11 converts one at a time per command byte, clocked by SCLK.
// - Mode 11 updates serial output on SCLK rising edge, else falling edge.
// - In mode 11, two NOPs after a channel conversion byte power down the analog cells.
// - Bias-keep-on bit holds the bias block powered between conversions.
// - Temperature result shifts out during the last two of the 24 NOP bytes after a temperature request.
// - In mode 11, temperature request skips analog channels and ignores channel select.
// - Internal modes convert each channel once, repeated only in scan mode 10.
// - Internal scans add 53.1 us when temperature is requested.
// - Clock mode field 11 selects the externally clocked mode.
// - Low load input copies every DAC input register to its DAC register.
// - Load input held low makes DAC registers transparent.
// - Software DAC update takes effect at chip-select rise after last bit.
// - DAC command cut short of 24 clocks (prefix byte plus 16-bit word) is discarded.
// - Results are two bytes, MSB first, led by four zero bits.
// - Clock mode 10 is selected after reset.
`timescale 1ns/1ps
module ascc_top import ascc_pkg::*; (
   // Core clock and reset
   input  wire logic              CORE_CLK,
   input  wire logic              RESETN,
   // Serial link
   input  wire logic              SCLK,
   input  wire logic              CS_N,
   input  wire logic              DIN,
   output logic                   DOUT,
   // Analog front end
   input  wire logic [11:0]       ADC_RESULT,
   input  wire logic [11:0]       TEMP_RESULT,
   input  wire logic [3:0]        SCAN_REPEAT_COUNT,
   output logic                   ANALOG_POWER_ON,
   output logic                   BIAS_POWER_ON,
   output logic                   CONV_START,
   output logic [3:0]             CONV_CHANNEL,
   output logic                   TEMP_MEASURE,
   output logic                   SCAN_BUSY,
   output logic [1:0]             CLOCK_MODE,
   // DAC
   input  wire logic              DAC_LOAD_N,
   output logic [7:0][11:0]       DAC_CODES
);
   // Link domain
   logic [2:0]          lbit_r;
   logic [1:0]          dac_load_n_r;
   logic [6:0]          lin_r;
   logic [7:0]          lbyte_r;
   logic                ltog_r;
   logic [1:0]          lmode_r;
   logic [15:0]         out_sh_r;
   logic [4:0]          out_cnt_r;
   logic                ltemp_r;
   logic [4:0]          ltemp_cnt_r;
   logic                dout_fall_r;
   logic [7:0]          rx_byte;
   logic                rx_done;
   ascc_conv_cmd_type   rx_cmd;
   // Core domain
   logic                cs_s;
   logic                load_n_s;
   logic                tog_s;
   logic                tog_seen_r;
   logic                cs_prev_r;
   logic                byte_ev;
   logic                cs_rise;
   ascc_conv_cmd_type   cmd;
   logic [7:0]          cbyte;
   logic                is_cmd;
   logic [1:0]          mode_r;
   logic                bias_keep_r;
   logic                analog_on_r;
   logic [1:0]          nop_cnt_r;
   logic [4:0]          temp_nops_r;
   ascc_conv_state_type conv_st_r;
   ascc_dac_state_type  dac_st_r;
   ascc_dac_state_type  dac_st_nxt;
   logic [15:0]         dac_word_r;
   logic [15:0]         dac_word_nxt;
   ascc_dac_word_type   dword;
   logic [7:0][11:0]    dac_in_r;
   logic [7:0][11:0]    dac_in_nxt;
   logic                commit;
   logic [15:0]         scan_cnt_r;
   logic [15:0]         scan_load;
   logic [11:0]         adc_hold_r;
   logic [11:0]         temp_hold_r;

   // ---------------- Link side (SCLK) ----------------
   assign rx_byte = {lin_r, DIN};
   assign rx_done = (lbit_r == 3'h7);
   assign rx_cmd  = rx_byte;

   // Bit and DAC-byte counters end with the frame
   always_ff @(posedge SCLK or posedge CS_N) begin
      if (CS_N) begin
         lbit_r <= 3'h0;
         dac_load_n_r <= 2'h0;
      end else begin
         lbit_r <= lbit_r + 3'h1;
         if (rx_done && dac_load_n_r != 2'h0) begin
            dac_load_n_r <= dac_load_n_r - 2'h1;
         end else if (rx_done && rx_byte[7:4] == DAC_TAG) begin
            dac_load_n_r <= DAC_DATA_BYTES;
         end
      end
   end

   always_ff @(posedge SCLK or negedge RESETN) begin
      if (!RESETN) begin
         lin_r   <= 7'h00;
         lbyte_r <= 8'h00;
         ltog_r  <= 1'b0;
      end else begin
         lin_r <= rx_byte[6:0];
         if (rx_done) begin
            lbyte_r <= rx_byte;
            ltog_r  <= ~ltog_r;
         end
      end
   end

   // Result shifter; survives a chip-select pulse mid conversion
   always_ff @(posedge SCLK or negedge RESETN) begin
      if (!RESETN) begin
         lmode_r     <= MODE_RESET;
         out_sh_r    <= 16'h0000;
         out_cnt_r   <= 5'h00;
         ltemp_r     <= 1'b0;
         ltemp_cnt_r <= 5'h00;
      end else begin
         if (out_cnt_r != 5'h00) begin
            out_sh_r  <= {out_sh_r[14:0], 1'b0};
            out_cnt_r <= out_cnt_r - 5'h01;
         end
         if (rx_done && dac_load_n_r == 2'h0) begin
            if (rx_byte[7:6] == SETUP_TAG) begin
               lmode_r <= rx_byte[SETUP_MODE_LSB +: 2];
            end
            if (rx_cmd.is_conv && lmode_r == MODE_EXT_SCLK) begin
               if (rx_cmd.temp) begin
                  ltemp_r     <= 1'b1;
                  ltemp_cnt_r <= 5'h00;
               end else begin
                  out_sh_r  <= {LEAD_ZEROS, adc_hold_r};
                  out_cnt_r <= RESULT_BITS;
               end
            end else if (ltemp_r && rx_byte == NOP_BYTE) begin
               ltemp_cnt_r <= ltemp_cnt_r + 5'h01;
               if (ltemp_cnt_r == TEMP_NOP_BYTES - TEMP_OUT_BYTES - 5'h01) begin
                  ltemp_r   <= 1'b0;
                  out_sh_r  <= {LEAD_ZEROS, temp_hold_r};
                  out_cnt_r <= RESULT_BITS;
               end
            end
         end
      end
   end

   // Falling-edge copy for the other clock modes
   always_ff @(negedge SCLK or negedge RESETN) begin
      if (!RESETN) begin
         dout_fall_r <= 1'b0;
      end else begin
         dout_fall_r <= out_sh_r[15];
      end
   end

   assign DOUT = !CS_N && ((lmode_r == MODE_EXT_SCLK) ? out_sh_r[15] : dout_fall_r);

   a_dout_rise_only: assert property (@(negedge SCLK) disable iff (!RESETN)
      (lmode_r == MODE_EXT_SCLK && !CS_N) |-> DOUT == out_sh_r[15])
      else $error("serial output not taken from the rising-edge shifter");

   // ---------------- Core side (CORE_CLK) ----------------
   ascc_sync #(.W(2), .INIT(2'h3)) u_pin_sync (
      .clk   (CORE_CLK),
      .rst_n (RESETN),
      .d     ({CS_N, DAC_LOAD_N}),
      .q     ({cs_s, load_n_s})
   );

   ascc_sync #(.W(1), .INIT(1'b0)) u_byte_sync (
      .clk   (CORE_CLK),
      .rst_n (RESETN),
      .d     (ltog_r),
      .q     (tog_s)
   );

   assign byte_ev = tog_s ^ tog_seen_r;
   assign cs_rise = cs_s && !cs_prev_r;
   assign cbyte   = lbyte_r;
   assign cmd     = lbyte_r;
   assign is_cmd  = byte_ev && dac_st_r == DW_IDLE;

   always_ff @(posedge CORE_CLK) begin
      if (!RESETN) begin
         tog_seen_r  <= 1'b0;
         cs_prev_r   <= 1'b1;
         adc_hold_r  <= 12'h000;
         temp_hold_r <= 12'h000;
      end else begin
         tog_seen_r <= tog_s;
         cs_prev_r  <= cs_s;
         // Held steady while a frame runs so the link can read them directly
         if (cs_s) begin
            adc_hold_r  <= ADC_RESULT;
            temp_hold_r <= TEMP_RESULT;
         end
      end
   end

   // Configuration bytes
   always_ff @(posedge CORE_CLK) begin
      if (!RESETN) begin
         mode_r      <= MODE_RESET;
         bias_keep_r <= 1'b0;
      end else if (is_cmd) begin
         if (cbyte[7:6] == SETUP_TAG) begin
            mode_r <= cbyte[SETUP_MODE_LSB +: 2];
         end
         if (cbyte[7:4] == RESET_TAG) begin
            bias_keep_r <= cbyte[RESET_BIAS_BIT];
         end
      end
   end

   // Externally clocked conversion sequencing and NOP power-down
   always_ff @(posedge CORE_CLK) begin
      if (!RESETN) begin
         conv_st_r    <= CV_IDLE;
         analog_on_r  <= 1'b0;
         nop_cnt_r    <= 2'h0;
         temp_nops_r  <= 5'h00;
         CONV_CHANNEL <= 4'h0;
         TEMP_MEASURE <= 1'b0;
      end else if (is_cmd && cmd.is_conv && mode_r == MODE_EXT_SCLK) begin
         analog_on_r <= 1'b1;
         nop_cnt_r   <= 2'h0;
         temp_nops_r <= 5'h00;
         if (cmd.temp) begin
            conv_st_r    <= CV_TEMP;
            TEMP_MEASURE <= 1'b1;
         end else begin
            conv_st_r    <= CV_RUN;
            CONV_CHANNEL <= cmd.chan;
            TEMP_MEASURE <= 1'b0;
         end
      end else if (is_cmd && cbyte == NOP_BYTE) begin
         unique case (conv_st_r)
            CV_IDLE: begin
            end
            CV_RUN: begin
               nop_cnt_r <= nop_cnt_r + 2'h1;
               if (nop_cnt_r == NOP_POWER_DOWN - 2'h1) begin
                  analog_on_r <= 1'b0;
                  conv_st_r   <= CV_IDLE;
               end
            end
            CV_TEMP: begin
               temp_nops_r <= temp_nops_r + 5'h01;
               if (temp_nops_r == TEMP_NOP_BYTES - 5'h01) begin
                  conv_st_r    <= CV_RUN;
                  TEMP_MEASURE <= 1'b0;
                  nop_cnt_r    <= 2'h0;
               end
            end
         endcase
      end
   end

   // Internally timed scan duration
   assign scan_load = ((cmd.scan == SCAN_REPEAT) ? {12'h000, SCAN_REPEAT_COUNT} : 16'h0001) * CONV_CYCLES
                      + (cmd.temp ? TEMP_CYCLES : 16'h0000);

   always_ff @(posedge CORE_CLK) begin
      if (!RESETN) begin
         scan_cnt_r <= 16'h0000;
         CONV_START <= 1'b0;
      end else begin
         CONV_START <= is_cmd && cmd.is_conv;
         if (is_cmd && cmd.is_conv && mode_r != MODE_EXT_SCLK && scan_cnt_r == 16'h0000) begin
            scan_cnt_r <= scan_load;
         end else if (scan_cnt_r != 16'h0000) begin
            scan_cnt_r <= scan_cnt_r - 16'h0001;
         end
      end
   end

   assign SCAN_BUSY       = (scan_cnt_r != 16'h0000);
   assign ANALOG_POWER_ON = analog_on_r || SCAN_BUSY;
   assign BIAS_POWER_ON   = ANALOG_POWER_ON || bias_keep_r;
   assign CLOCK_MODE      = mode_r;

   // DAC command framing: prefix byte then a 16-bit word
   always_comb begin
      dac_st_nxt   = dac_st_r;
      dac_word_nxt = dac_word_r;
      if (byte_ev) begin
         unique case (dac_st_r)
            DW_IDLE: begin
               if (cbyte[7:4] == DAC_TAG) begin
                  dac_st_nxt = DW_HI;
               end
            end
            DW_HI: begin
               dac_word_nxt = {cbyte, dac_word_r[7:0]};
               dac_st_nxt   = DW_LO;
            end
            DW_LO: begin
               dac_word_nxt = {dac_word_r[15:8], cbyte};
               dac_st_nxt   = DW_FULL;
            end
            DW_FULL: begin
            end
         endcase
      end
   end

   assign dword  = dac_word_nxt;
   assign commit = cs_rise && dac_st_nxt == DW_FULL;

   always_comb begin
      dac_in_nxt = dac_in_r;
      if (commit) begin
         dac_in_nxt[dword.chan] = dword.code;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RESETN) begin
         dac_st_r   <= DW_IDLE;
         dac_word_r <= 16'h0000;
         dac_in_r   <= {8{DAC_RESET_CODE}};
      end else begin
         dac_word_r <= dac_word_nxt;
         dac_in_r   <= dac_in_nxt;
         dac_st_r   <= cs_rise ? DW_IDLE : dac_st_nxt;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RESETN) begin
         DAC_CODES <= {8{DAC_RESET_CODE}};
      end else if (!load_n_s || (commit && dword.sw_load)) begin
         DAC_CODES <= dac_in_nxt;
      end
   end

   // ---------------- Checks ----------------
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RESETN);

   a_mode_after_reset: assert property ($past(!RESETN) |-> mode_r == MODE_RESET)
      else $error("clock mode not 10 after reset");

   a_bias_kept_on: assert property (bias_keep_r |-> BIAS_POWER_ON)
      else $error("bias dropped while keep-on set");

   a_nop_power_down: assert property ((is_cmd && cbyte == NOP_BYTE && conv_st_r == CV_RUN
      && nop_cnt_r == 2'h1) |=> !analog_on_r ##1 !analog_on_r or is_cmd)
      else $error("analog cells stayed up after second NOP");

   a_dac_hold: assert property ((load_n_s && !(commit && dword.sw_load)) |=> $stable(DAC_CODES))
      else $error("DAC register moved without a load");

   a_dac_transparent: assert property ((!load_n_s && commit) ##1 !load_n_s
      |-> DAC_CODES[$past(dword.chan)] == $past(dword.code))
      else $error("DAC register not transparent under held load");

   a_dac_discard: assert property ((cs_rise && dac_st_nxt != DW_FULL) |=> $stable(dac_in_r))
      else $error("short DAC command was applied");

   a_sw_update: assert property ((commit && dword.sw_load) |=> DAC_CODES == $past(dac_in_nxt))
      else $error("software DAC update missed at chip-select rise");

   a_temp_chan_kept: assert property ((is_cmd && cmd.is_conv && cmd.temp && mode_r == MODE_EXT_SCLK)
      |=> $stable(CONV_CHANNEL) && TEMP_MEASURE)
      else $error("temperature request touched channel select");

   a_scan_temp_time: assert property ((is_cmd && cmd.is_conv && cmd.temp && mode_r != MODE_EXT_SCLK
      && !SCAN_BUSY) |=> scan_cnt_r >= TEMP_CYCLES)
      else $error("temperature time missing from scan");

   a_no_scan_ext: assert property ((mode_r == MODE_EXT_SCLK && !SCAN_BUSY) |=> !SCAN_BUSY)
      else $error("scan started in externally clocked mode");
endmodule

// ===== ascc_host_model.sv
/*
 * Serial host model: frames whole bytes with its own chip select, MSB first.
 * Assumes the device samples din on the rising edge; the host changes din on
 * the falling edge and samples dout just before each rising edge.
 */
`timescale 1ns/1ps
module ascc_host_model (
   // Serial link
   output logic      sclk,
   output logic      cs_n,
   output logic      din,
   input  wire logic dout
);
   int fall_chg;

   initial begin
      sclk     = 1'b0;
      cs_n     = 1'b1;
      din      = 1'b1;
      fall_chg = 0;
   end

   // Clock stands low outside frames; din inverts once the frame ends
   task automatic frame(input int n, input logic [31:0] tx, output logic [31:0] rx);
      logic b;
      logic fb;
      rx   = '0;
      cs_n = 1'b0;
      #60;
      for (int i = 0; i < 8 * n; i++) begin
         din = tx[31-i];
         #62.5;
         b    = dout;
         sclk = 1'b1;
         #61.5;
         fb   = dout;
         sclk = 1'b0;
         rx   = {rx[30:0], b};
         #1;
         if (dout !== fb) begin
            fall_chg++;
         end
      end
      #60;
      cs_n = 1'b1;
      din  = ~din;
      #250;
   endtask
endmodule

// ===== tb.sv
/*
 * Self-checking bench for the externally clocked conversion sequencer.
 * Assumes the host model drives the link at 125 ns per bit, unrelated to the
 * 40 ns core clock, and that the analog results are held steady between frames.
 */
`timescale 1ns/1ps
module tb import ascc_pkg::*;;
   logic             clk;
   logic             rstn;
   wire              sclk;
   wire              cs_n;
   wire              din;
   logic             dout;
   logic [11:0]      adc_res;
   logic [11:0]      temp_res;
   logic [3:0]       rep;
   logic             apo;
   logic             bpo;
   logic             cst;
   logic [3:0]       cch;
   logic             tm;
   logic             sb;
   logic [1:0]       cm;
   logic             ldn;
   logic [7:0][11:0] codes;
   logic [31:0]      rx;
   int               bad_count;
   int               checks_done;
   int               starts;
   int               busy_cyc;

   ascc_host_model host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

   ascc_top uut (
      .CORE_CLK(clk), .RESETN(rstn), .SCLK(sclk), .CS_N(cs_n), .DIN(din), .DOUT(dout),
      .ADC_RESULT(adc_res), .TEMP_RESULT(temp_res), .SCAN_REPEAT_COUNT(rep),
      .ANALOG_POWER_ON(apo), .BIAS_POWER_ON(bpo), .CONV_START(cst), .CONV_CHANNEL(cch),
      .TEMP_MEASURE(tm), .SCAN_BUSY(sb), .CLOCK_MODE(cm), .DAC_LOAD_N(ldn), .DAC_CODES(codes)
   );

   always #20 clk = ~clk;

   // Count on the falling edge so the design's outputs have settled
   always @(negedge clk) begin
      if (cst === 1'b1) begin
         starts++;
      end
      if (sb === 1'b1) begin
         busy_cyc++;
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic frm(input int n, input logic [31:0] tx);
      host.frame(n, tx, rx);
      cyc(8);
   endtask

   task automatic end_sim;
      if (bad_count == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic t_reset;
      chk(32'(cm), 32'(MODE_INT_CMD));
      chk(32'(codes[0]), 32'(DAC_RESET_CODE));
      chk(32'(apo), 32'h0);
   endtask

   task automatic t_ext_conv;
      frm(1, 32'h7000_0000);
      chk(32'(cm), 32'(MODE_EXT_SCLK));
      adc_res       = 12'ha5c;
      host.fall_chg = 0;
      frm(3, 32'hac00_0000);
      chk(32'(rx[15:0]), 32'h0000_0a5c);
      chk(32'(host.fall_chg), 32'h0);
      chk(32'(cch), 32'h5);
      chk(32'(sb), 32'h0);
      chk(32'(apo), 32'h0);
   endtask

   task automatic t_nop_pace;
      starts = 0;
      frm(4, 32'hc000_9800);
      chk(32'(starts), 32'h2);
      chk(32'(cch), 32'h3);
      chk(32'(apo), 32'h1);
      frm(1, 32'h0);
      chk(32'(apo), 32'h0);
      chk(32'(bpo), 32'h0);
      frm(1, 32'h1800_0000);
      chk(32'(bpo), 32'h1);
      frm(1, 32'h1000_0000);
      chk(32'(bpo), 32'h0);
   endtask

   task automatic t_temp;
      logic [23:0] seq;
      seq      = '0;
      temp_res = 12'h3c7;
      frm(1, 32'h8100_0000);
      chk(32'(tm), 32'h1);
      for (int k = 1; k <= 24; k++) begin
         host.frame(1, 32'h0, rx);
         seq = {seq[15:0], rx[7:0]};
         if (k == 23) begin
            cyc(8);
            chk(32'(tm), 32'h1);
         end
      end
      cyc(8);
      chk(32'(seq[15:0]), 32'h0000_03c7);
      chk(32'(tm), 32'h0);
      chk(32'(cch), 32'h3);
   endtask

   task automatic run_scan(input logic [7:0] cmd, input int exp);
      int n;
      n        = 0;
      busy_cyc = 0;
      host.frame(1, {cmd, 24'h0}, rx);
      while (sb !== 1'b0 && n < 3000) begin
         cyc(1);
         n++;
      end
      chk(32'(busy_cyc), 32'(exp));
   endtask

   task automatic t_scan;
      frm(1, 32'h6000_0000);
      run_scan(8'h94, 3 * int'(CONV_CYCLES));
      run_scan(8'h90, int'(CONV_CYCLES));
      run_scan(8'h91, int'(CONV_CYCLES) + int'(TEMP_CYCLES));
   endtask

   task automatic t_dac;
      frm(3, 32'h3025_a100);
      cyc(4);
      chk(32'(codes[2]), 32'h0);
      ldn = 1'b0;
      cyc(10);
      chk(32'(codes[2]), 32'h5a1);
      frm(3, 32'h3060_f300);
      cyc(6);
      chk(32'(codes[6]), 32'h0f3);
      ldn = 1'b1;
      cyc(6);
      frm(3, 32'h3021_1100);
      cyc(4);
      chk(32'(codes[2]), 32'h5a1);
      frm(2, 32'h30a7_0000);
      cyc(4);
      chk(32'(codes[2]), 32'h5a1);
      frm(3, 32'h30f9_c400);
      cyc(4);
      chk(32'(codes[7]), 32'h9c4);
      chk(32'(codes[2]), 32'h111);
   endtask

   initial begin
      clk         = 1'b0;
      rstn        = 1'b0;
      adc_res     = 12'h000;
      temp_res    = 12'h000;
      rep         = 4'h3;
      ldn         = 1'b1;
      bad_count   = 0;
      checks_done = 0;
      starts      = 0;
      busy_cyc    = 0;
      cyc(3);
      rstn = 1'b1;
      cyc(6);
      t_reset();
      t_ext_conv();
      t_nop_pace();
      t_temp();
      t_scan();
      t_dac();
      end_sim();
   end

   // Whole run needs well under half a millisecond
   initial begin
      #1_000_000;
      bad_count++;
      end_sim();
   end
endmodule
